// File: src/flash_ecc_regs.sv
// What this block does
// - option area 0 error sets bit 19, offset
// - 15-bit offset captured on every ECC error
// - fault address is region base plus 8*offset
// - correct two-key sequence unlocks control register 0 unless a wrong or extra key write has locked it until reset
// - key register is write-only, reads zero
// - double error flag set, cleared by one-writes
// - double error interrupt when enabled and an EEPROM, option area 0 or option area 1 double error flag is set
module flash_ecc_regs #(
    parameter logic [31:0] KEY_FIRST = 32'h1111_1111,
    parameter logic [31:0] KEY_SECOND = 32'h2222_2222
) (
    input wire logic ref_clk, // 250 MHz core clock
    input wire logic rstn, // async reset, active low
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    input wire logic wb_we_i, // wishbone write
    input wire logic [7:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte lanes
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // wishbone ack
    input wire logic ecc_err_valid, // one-cycle ecc error event
    input wire logic ecc_err_double, // event is a two-bit error
    input wire logic [2:0] ecc_err_region, // region of the error
    input wire logic [14:0] ecc_err_offset, // double-word offset in region
    input wire logic system_flash_ecc_clear, // one-write to system flash ecc flag
    input wire logic control0_relock, // lock bit set in control register 0
    output logic flash_control0_unlocked, // control register 0 writable
    output logic ecc_irq, // ecc interrupt, level
    output logic irq // event interrupt, level
);

    logic rst_meta_r;
    logic rst_n_s;
    logic [31:0] ecccs_r;
    logic [4:0] sticky_r;
    logic [1:0] irq_en_r;
    logic [4:0] region_r;
    logic [flash_ecc_pkg::OFFSET_W-1:0] offset_r;
    logic [flash_ecc_pkg::IRQ_W-1:0] irq_stat_r;
    logic [flash_ecc_pkg::IRQ_W-1:0] irq_mask_r;
    logic req;
    logic wr_word;
    logic [31:0] w1c;
    logic [31:0] ecc_set;
    logic [flash_ecc_pkg::IRQ_W-1:0] ev_set;
    logic [31:0] rd_nxt;
    logic [31:0] clr_mask;
    key_port_if kp();

    // =========================================================
    // reset release
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_r <= 1'b0;
            rst_n_s <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_s <= rst_meta_r;
        end
    end

    // =========================================================
    // wishbone slave: ack one cycle after the request, write at ack edge
    assign req = wb_cyc_i && wb_stb_i;
    // partial-lane writes are dropped, the registers want whole words
    assign wr_word = req && wb_ack_o && wb_we_i && (wb_sel_i == flash_ecc_pkg::SEL_WORD);
    assign w1c = (wr_word && (wb_adr_i == flash_ecc_pkg::ECCCS_ADDR)) ? wb_dat_i : 32'h0000_0000;

    always_ff @(posedge ref_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req && !wb_ack_o;
        end
    end

    always_comb begin
        rd_nxt = 32'h0000_0000;
        case (wb_adr_i)
            flash_ecc_pkg::ECCCS_ADDR: rd_nxt = ecccs_r;
            flash_ecc_pkg::KEY_ADDR: rd_nxt = 32'h0000_0000;
            flash_ecc_pkg::IRQ_STAT_ADDR: rd_nxt = {29'h0000_0000, irq_stat_r};
            flash_ecc_pkg::IRQ_MASK_ADDR: rd_nxt = {29'h0000_0000, irq_mask_r};
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req && !wb_ack_o && !wb_we_i) begin
            wb_dat_o <= rd_nxt;
        end
    end

    // =========================================================
    // ecc status register
    always_comb begin
        ecc_set = 32'h0000_0000;
        if (ecc_err_valid) begin
            if (ecc_err_double) begin
                ecc_set[flash_ecc_pkg::DED_BIT] = 1'b1;
                ecc_set[flash_ecc_pkg::EEPROM_DED_BIT] = (ecc_err_region == flash_ecc_pkg::REG_EEPROM);
                ecc_set[flash_ecc_pkg::OB0_DED_BIT] = (ecc_err_region == flash_ecc_pkg::REG_OPT0);
                ecc_set[flash_ecc_pkg::OB1_DED_BIT] = (ecc_err_region == flash_ecc_pkg::REG_OPT1);
            end else begin
                ecc_set[flash_ecc_pkg::COR_BIT] = 1'b1;
            end
        end
    end

    // the double error flag also clears from the system status side
    always_comb begin
        clr_mask = 32'h0000_0000;
        clr_mask[flash_ecc_pkg::DED_BIT] = w1c[flash_ecc_pkg::DED_BIT] || system_flash_ecc_clear;
        clr_mask[flash_ecc_pkg::COR_BIT] = w1c[flash_ecc_pkg::COR_BIT];
        clr_mask[flash_ecc_pkg::EEPROM_DED_BIT] = w1c[flash_ecc_pkg::EEPROM_DED_BIT];
        clr_mask[flash_ecc_pkg::OB0_DED_BIT] = w1c[flash_ecc_pkg::OB0_DED_BIT];
        clr_mask[flash_ecc_pkg::OB1_DED_BIT] = w1c[flash_ecc_pkg::OB1_DED_BIT];
    end

    // sticky error flags 31,30,29,27,26: a new event beats a clear in the same cycle
    always_ff @(posedge ref_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            sticky_r <= {flash_ecc_pkg::ECCCS_RESET[31:29], flash_ecc_pkg::ECCCS_RESET[27:26]};
        end else begin
            sticky_r <= (sticky_r & ~{clr_mask[31:29], clr_mask[27:26]})
                        | {ecc_set[31:29], ecc_set[27:26]};
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            irq_en_r <= flash_ecc_pkg::ECCCS_RESET[flash_ecc_pkg::DED_IE_BIT:flash_ecc_pkg::COR_IE_BIT];
        end else if (wr_word && (wb_adr_i == flash_ecc_pkg::ECCCS_ADDR)) begin
            irq_en_r <= wb_dat_i[flash_ecc_pkg::DED_IE_BIT:flash_ecc_pkg::COR_IE_BIT];
        end
    end

    // region flags and offset describe the latest error only
    always_ff @(posedge ref_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            region_r <= flash_ecc_pkg::ECCCS_RESET[flash_ecc_pkg::OTP_FLAG_BIT:flash_ecc_pkg::OB0_FLAG_BIT];
            offset_r <= flash_ecc_pkg::ECCCS_RESET[flash_ecc_pkg::OFFSET_W-1:0];
        end else if (ecc_err_valid) begin
            region_r <= {(ecc_err_region == flash_ecc_pkg::REG_OTP),
                         (ecc_err_region == flash_ecc_pkg::REG_DATA),
                         (ecc_err_region == flash_ecc_pkg::REG_SYSTEM),
                         (ecc_err_region == flash_ecc_pkg::REG_BANK1),
                         (ecc_err_region == flash_ecc_pkg::REG_OPT0)};
            // offset in double words; byte address is base plus 8 times this
            offset_r <= ecc_err_offset;
        end
    end

    // reserved bits and bit 28 hold reset value whatever software writes
    assign ecccs_r = {sticky_r[4:2], 1'b0, sticky_r[1:0], irq_en_r, region_r,
                      {(flash_ecc_pkg::RSVD_HI - flash_ecc_pkg::RSVD_LO + 1){1'b0}},
                      offset_r};

    always_ff @(posedge ref_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            ecc_irq <= 1'b0;
        end else begin
            ecc_irq <= (ecccs_r[flash_ecc_pkg::DED_IE_BIT] && (ecccs_r[flash_ecc_pkg::EEPROM_DED_BIT]
                        || ecccs_r[flash_ecc_pkg::OB0_DED_BIT]
                        || ecccs_r[flash_ecc_pkg::OB1_DED_BIT]))
                       || (ecccs_r[flash_ecc_pkg::COR_IE_BIT] && ecccs_r[flash_ecc_pkg::COR_BIT]);
        end
    end

    // =========================================================
    // key register and lock
    assign kp.wr = wr_word && (wb_adr_i == flash_ecc_pkg::KEY_ADDR);
    assign kp.data = wb_dat_i;
    assign kp.relock = control0_relock;

    flash_key_unlock #(
        .KEY_FIRST(KEY_FIRST),
        .KEY_SECOND(KEY_SECOND)
    ) u_keys (
        .clk(ref_clk),
        .rst_n(rst_n_s),
        .kp(kp)
    );

    always_ff @(posedge ref_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            flash_control0_unlocked <= 1'b0;
        end else begin
            flash_control0_unlocked <= kp.unlocked;
        end
    end

    // =========================================================
    // event interrupts
    assign ev_set = {kp.fault, ecc_err_valid && !ecc_err_double, ecc_err_valid && ecc_err_double};

    always_ff @(posedge ref_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~((wr_word && (wb_adr_i == flash_ecc_pkg::IRQ_STAT_ADDR))
                          ? wb_dat_i[flash_ecc_pkg::IRQ_W-1:0] : 3'h0)) | ev_set;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            irq_mask_r <= '0;
        end else if (wr_word && (wb_adr_i == flash_ecc_pkg::IRQ_MASK_ADDR)) begin
            irq_mask_r <= wb_dat_i[flash_ecc_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_r & irq_mask_r);
        end
    end

    // =========================================================
    // checks
    ob0_flag_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
        ecc_err_valid && (ecc_err_region == flash_ecc_pkg::REG_OPT0)
        |=> ecccs_r[flash_ecc_pkg::OB0_FLAG_BIT] && !ecccs_r[flash_ecc_pkg::BK1_FLAG_BIT])
        else $error("option area 0 flag not set");
    offset_capture_a: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
        ecc_err_valid |=> ecccs_r[14:0] == $past(ecc_err_offset))
        else $error("fault offset not captured");
    ded_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
        ecc_err_valid && ecc_err_double |=> ecccs_r[flash_ecc_pkg::DED_BIT])
        else $error("double error flag not set");
    ded_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
        system_flash_ecc_clear && !ecc_err_valid |=> !ecccs_r[flash_ecc_pkg::DED_BIT])
        else $error("double error flag not cleared");
    ded_irq_a: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
        ecccs_r[flash_ecc_pkg::DED_IE_BIT] && ecccs_r[flash_ecc_pkg::OB0_DED_BIT] |=> ecc_irq)
        else $error("double error interrupt missing");
    key_read_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
        wb_ack_o && req && !wb_we_i && (wb_adr_i == flash_ecc_pkg::KEY_ADDR) |-> wb_dat_o == 32'h0)
        else $error("key register read back nonzero");
    reserved_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
        ecccs_r[flash_ecc_pkg::RSVD_HI:flash_ecc_pkg::RSVD_LO] == 4'h0)
        else $error("reserved bits not zero");
    key_word_only_a: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
        req && wb_we_i && (wb_sel_i != flash_ecc_pkg::SEL_WORD) |-> !kp.wr)
        else $error("partial write reached the key");
    ack_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
        req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single pulse");
    unlock_path_a: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
        kp.fault |=> !flash_control0_unlocked [*3])
        else $error("unlocked after wrong key");
    ded_cover: cover property (@(posedge ref_clk) disable iff (!rst_n_s)
        ecc_err_valid && ecc_err_double ##[1:4] ecc_irq);
    irq_cover: cover property (@(posedge ref_clk) disable iff (!rst_n_s) $rose(irq));
    unlocked_cover: cover property (@(posedge ref_clk) disable iff (!rst_n_s)
        $rose(flash_control0_unlocked));

endmodule : flash_ecc_regs

// File: src/flash_ecc_pkg.sv
package flash_ecc_pkg;

    // =========================================================
    // register map, byte addresses on the word bus
    localparam logic [7:0] ECCCS_ADDR = 8'h04;
    localparam logic [7:0] KEY_ADDR = 8'h08;
    localparam logic [7:0] IRQ_STAT_ADDR = 8'h40;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'h44;
    localparam logic [3:0] SEL_WORD = 4'hF;
    localparam logic [31:0] ECCCS_RESET = 32'h0000_0000;
    localparam logic [31:0] KEY_RESET = 32'h0000_0000;

    // =========================================================
    // ecc status field positions
    localparam int DED_BIT = 31;
    localparam int COR_BIT = 30;
    localparam int EEPROM_DED_BIT = 29;
    localparam int OB0_DED_BIT = 27;
    localparam int OB1_DED_BIT = 26;
    localparam int DED_IE_BIT = 25;
    localparam int COR_IE_BIT = 24;
    localparam int OTP_FLAG_BIT = 23;
    localparam int DF_FLAG_BIT = 22;
    localparam int SYS_FLAG_BIT = 21;
    localparam int BK1_FLAG_BIT = 20;
    localparam int OB0_FLAG_BIT = 19;
    localparam int RSVD_HI = 18;
    localparam int RSVD_LO = 15;
    localparam int OFFSET_W = 15;
    localparam int BYTES_PER_DWORD = 8;

    // =========================================================
    // own interrupt status and mask layout
    localparam int IRQ_W = 3;
    localparam int EV_DED = 0;
    localparam int EV_COR = 1;
    localparam int EV_KEY_FAULT = 2;

    typedef enum logic [2:0] {
        REG_BANK0 = 3'h0,
        REG_BANK1 = 3'h1,
        REG_DATA = 3'h2,
        REG_EEPROM = 3'h3,
        REG_SYSTEM = 3'h4,
        REG_OPT0 = 3'h5,
        REG_OPT1 = 3'h6,
        REG_OTP = 3'h7
    } region_type;

    typedef enum logic [3:0] {
        KEY_LOCKED = 4'b0001,
        KEY_HALF = 4'b0010,
        KEY_OPEN = 4'b0100,
        KEY_DEAD = 4'b1000
    } key_state_type;

endpackage : flash_ecc_pkg

// File: src/key_port_if.sv
interface key_port_if;
    logic wr;
    logic [31:0] data;
    logic relock;
    logic unlocked;
    logic fault;

    modport regs (output wr, output data, output relock, input unlocked, input fault);
    modport keys (input wr, input data, input relock, output unlocked, output fault);
endinterface : key_port_if

// File: src/flash_key_unlock.sv
module flash_key_unlock #(
    parameter logic [31:0] KEY_FIRST = 32'h1111_1111,
    parameter logic [31:0] KEY_SECOND = 32'h2222_2222
) (
    input wire logic clk, // core clock
    input wire logic rst_n, // synchronised reset, active low
    key_port_if.keys kp // key writes in, lock state out
);

    flash_ecc_pkg::key_state_type state_r;
    flash_ecc_pkg::key_state_type state_nxt;

    // =========================================================
    // key sequence
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            flash_ecc_pkg::KEY_LOCKED: begin
                if (kp.wr) begin
                    state_nxt = (kp.data == KEY_FIRST) ? flash_ecc_pkg::KEY_HALF
                                                       : flash_ecc_pkg::KEY_DEAD;
                end
            end
            flash_ecc_pkg::KEY_HALF: begin
                if (kp.wr) begin
                    state_nxt = (kp.data == KEY_SECOND) ? flash_ecc_pkg::KEY_OPEN
                                                        : flash_ecc_pkg::KEY_DEAD;
                end
            end
            flash_ecc_pkg::KEY_OPEN: begin
                // any key write while open is a misuse and locks for good
                if (kp.wr) begin
                    state_nxt = flash_ecc_pkg::KEY_DEAD;
                end else if (kp.relock) begin
                    state_nxt = flash_ecc_pkg::KEY_LOCKED;
                end
            end
            flash_ecc_pkg::KEY_DEAD: state_nxt = flash_ecc_pkg::KEY_DEAD;
            default: state_nxt = flash_ecc_pkg::KEY_DEAD;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= flash_ecc_pkg::KEY_LOCKED;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            kp.unlocked <= 1'b0;
            kp.fault <= 1'b0;
        end else begin
            kp.unlocked <= (state_nxt == flash_ecc_pkg::KEY_OPEN);
            kp.fault <= (state_nxt == flash_ecc_pkg::KEY_DEAD)
                        && (state_r != flash_ecc_pkg::KEY_DEAD);
        end
    end

    // =========================================================
    // checks
    unlock_needs_key_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(kp.unlocked) |-> $past(kp.wr) && ($past(kp.data) == KEY_SECOND))
        else $error("unlocked without the second key");
    wrong_key_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
        kp.fault |-> !kp.unlocked ##1 (!kp.unlocked && !kp.fault) [*8])
        else $error("unlocked after a wrong key");
    unlock_cover: cover property (@(posedge clk) disable iff (!rst_n) $rose(kp.unlocked));
    fault_cover: cover property (@(posedge clk) disable iff (!rst_n) kp.fault);

endmodule : flash_key_unlock

// File: verif/flash_ecc_regs_tb.sv
module flash_ecc_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // =========================================================
    // clock, reset, stimulus signals
    localparam logic [31:0] K1 = 32'h1111_1111;
    localparam logic [31:0] K2 = 32'h2222_2222;
    localparam logic [31:0] W1C_ALL = 32'hEC00_0000;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] rdat, q;
    logic ack, unlocked, ecc_irq, irq;
    logic ev_valid = 1'b0, ev_double = 1'b0, sys_clear = 1'b0, relock = 1'b0;
    logic [2:0] ev_region = 3'h0;
    logic [14:0] ev_offset = 15'h0000;
    int seed = 32'h217c81f6;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;

    always #2 ref_clk = ~ref_clk;

    flash_ecc_regs #(.KEY_FIRST(K1), .KEY_SECOND(K2)) flash_ecc_regs_inst (
        .ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .ecc_err_valid(ev_valid), .ecc_err_double(ev_double), .ecc_err_region(ev_region),
        .ecc_err_offset(ev_offset), .system_flash_ecc_clear(sys_clear),
        .control0_relock(relock), .flash_control0_unlocked(unlocked),
        .ecc_irq(ecc_irq), .irq(irq)
    );

    // =========================================================
    // reporting
    task automatic tally_and_finish();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk32

    task automatic chk1(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk1

    // hang guard: whole run is a few hundred cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            tally_and_finish();
        end
    end

    // =========================================================
    // bus and event drivers
    // request held until the rising edge that samples ack high; read data taken there
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        do @(posedge ref_clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0000_0000, 4'hF);
        chk32(q, exp);
    endtask : rd_chk

    task automatic ecc_ev(input logic [2:0] r, input logic [14:0] o, input logic d);
        @(posedge ref_clk);
        ev_valid <= 1'b1;
        ev_region <= r;
        ev_offset <= o;
        ev_double <= d;
        @(posedge ref_clk);
        ev_valid <= 1'b0;
        ev_offset <= ~o;
        repeat (2) @(posedge ref_clk);
    endtask : ecc_ev

    task automatic pulse(input logic pick_relock);
        @(posedge ref_clk);
        if (pick_relock) begin
            relock <= 1'b1;
        end else begin
            sys_clear <= 1'b1;
        end
        @(posedge ref_clk);
        relock <= 1'b0;
        sys_clear <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask : pulse

    // expected status word for one event after all sticky flags were cleared
    function automatic logic [31:0] ecc_exp(input logic [2:0] r, input logic [14:0] o,
                                            input logic d);
        logic [31:0] e;
        e = {17'h00000, o};
        e[31] = d;
        e[30] = !d;
        e[29] = d && r == 3'h3;
        e[27] = d && r == 3'h5;
        e[26] = d && r == 3'h6;
        case (r)
            3'h1: e[20] = 1'b1;
            3'h2: e[22] = 1'b1;
            3'h4: e[21] = 1'b1;
            3'h5: e[19] = 1'b1;
            3'h7: e[23] = 1'b1;
            default: e = e;
        endcase
        return e;
    endfunction : ecc_exp

    function automatic logic [31:0] fault_addr(input logic [31:0] base, input logic [14:0] o);
        return base + {17'h00000, o} * 8;
    endfunction : fault_addr

    // =========================================================
    // main sequence
    initial begin : main
        logic [2:0] r;
        logic [14:0] o;
        logic d;
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd_chk(8'h04, 32'h0000_0000);
        rd_chk(8'h08, 32'h0000_0000);
        wb(1'b1, 8'h20, 32'hFFFF_FFFF, 4'hF);
        rd_chk(8'h20, 32'h0000_0000);
        for (int i = 0; i < 24; i++) begin
            r = (i < 8) ? i[2:0] : 3'($random(seed));
            o = (i == 0) ? 15'h7FFF : 15'($random(seed));
            d = (i < 16) ? i[3] : 1'($random(seed));
            ecc_ev(r, o, d);
            rd_chk(8'h04, ecc_exp(r, o, d));
            chk32(fault_addr(32'h0800_0000, q[14:0]), 32'h0800_0000 + o * 8);
            wb(1'b1, 8'h04, W1C_ALL, 4'hF);
            chk1(ecc_irq, 1'b0);
        end
        wb(1'b1, 8'h04, 32'h0200_0000, 4'hF);
        ecc_ev(3'h0, 15'h0001, 1'b1);
        chk1(ecc_irq, 1'b0);
        pulse(1'b0);
        rd_chk(8'h04, 32'h0200_0001);
        for (int k = 0; k < 3; k++) begin
            r = (k == 0) ? 3'h3 : ((k == 1) ? 3'h5 : 3'h6);
            ecc_ev(r, 15'h0002, 1'b1);
            chk1(ecc_irq, 1'b1);
            wb(1'b1, 8'h04, W1C_ALL | 32'h0200_0000, 4'hF);
            repeat (2) @(posedge ref_clk);
            chk1(ecc_irq, 1'b0);
        end
        rd_chk(8'h04, 32'h0200_0002);
        // corrected-error interrupt path, enables swapped over
        wb(1'b1, 8'h04, 32'h0100_0000, 4'hF);
        ecc_ev(3'h2, 15'h0005, 1'b0);
        chk1(ecc_irq, 1'b1);
        rd_chk(8'h04, 32'h4140_0005);
        wb(1'b1, 8'h04, W1C_ALL, 4'hF);
        repeat (2) @(posedge ref_clk);
        chk1(ecc_irq, 1'b0);
        wb(1'b1, 8'h40, 32'h0000_0007, 4'hF);
        wb(1'b1, 8'h44, 32'h0000_0001, 4'hF);
        rd_chk(8'h44, 32'h0000_0001);
        ecc_ev(3'h1, 15'h0003, 1'b1);
        chk1(irq, 1'b1);
        wb(1'b1, 8'h44, 32'h0000_0000, 4'hF);
        repeat (2) @(posedge ref_clk);
        chk1(irq, 1'b0);
        rd_chk(8'h40, 32'h0000_0001);
        wb(1'b1, 8'h40, 32'h0000_0001, 4'hF);
        rd_chk(8'h40, 32'h0000_0000);
        // key sequence, relock, partial-lane refusal, then a wrong key
        chk1(unlocked, 1'b0);
        wb(1'b1, 8'h08, K1, 4'hF);
        wb(1'b1, 8'h08, K2, 4'hF);
        repeat (2) @(posedge ref_clk);
        chk1(unlocked, 1'b1);
        rd_chk(8'h08, 32'h0000_0000);
        pulse(1'b1);
        chk1(unlocked, 1'b0);
        wb(1'b1, 8'h08, K1, 4'h3);
        wb(1'b1, 8'h08, K1, 4'hF);
        wb(1'b1, 8'h08, K2, 4'hF);
        repeat (2) @(posedge ref_clk);
        chk1(unlocked, 1'b1);
        pulse(1'b1);
        wb(1'b1, 8'h44, 32'h0000_0004, 4'hF);
        wb(1'b1, 8'h08, 32'($random(seed)) | 32'h8000_0000, 4'hF);
        // fault flop, then status bit, then the registered irq
        repeat (3) @(posedge ref_clk);
        chk1(irq, 1'b1);
        rd_chk(8'h40, 32'h0000_0004);
        wb(1'b1, 8'h08, K1, 4'hF);
        wb(1'b1, 8'h08, K2, 4'hF);
        pulse(1'b1);
        wb(1'b1, 8'h08, K1, 4'hF);
        wb(1'b1, 8'h08, K2, 4'hF);
        repeat (3) @(posedge ref_clk);
        chk1(unlocked, 1'b0);
        tally_and_finish();
    end : main
endmodule : flash_ecc_regs_tb
